//--- core/spsc_pkg.sv
// Package for standby pin state control: mode codes, widths, filter figures.
// Assumes a single 25 MHz clock domain; one machine-clock period equals one clock.
package spsc_pkg;
  // Operating modes as presented by the standby sequencer
  localparam logic [2:0] SPSC_MODE_NORMAL = 3'h0;
  localparam logic [2:0] SPSC_MODE_SLEEP = 3'h1;
  localparam logic [2:0] SPSC_MODE_STOP = 3'h2;
  localparam logic [2:0] SPSC_MODE_WATCH = 3'h3;
  localparam int SPSC_PINS = 8;
  localparam int SPSC_EVENTS = 3;
  // Least pulse width on event inputs, in machine-clock periods
  localparam int SPSC_MIN_PULSE_MCLK = 2;
  localparam logic [7:0] SPSC_DIR_RESET = 8'h00;
  localparam logic [7:0] SPSC_DATA_RESET = 8'h00;
  localparam logic [1:0] SPSC_OSC_RESET = 2'h0;
  // Oscillator function stays live while reset is applied
  localparam logic [1:0] SPSC_OSC_ACT_RESET = 2'h3;
endpackage : spsc_pkg

//--- core/spsc_pulse_filter.sv
// Event input pulse qualifier: two-stage synchroniser and a level filter.
// Assumes the input is asynchronous; a level is passed once it has held
// for the least pulse width in machine-clock periods.
`timescale 1ns/1ps
module spsc_pulse_filter #(
  parameter int MIN_PULSE = spsc_pkg::SPSC_MIN_PULSE_MCLK
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic pin_in,
  output logic level_out,
  output logic rise_out
);
  logic sync1_r;
  logic sync2_r;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic stable_w;
  localparam logic [3:0] LIMIT = 4'(MIN_PULSE - 1);

  assign stable_w = (sync2_r != level_out) && (cnt_r >= LIMIT);
  assign cnt_nxt = (sync2_r == level_out) ? 4'h0 : (stable_w ? 4'h0 : cnt_r + 4'h1);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      cnt_r <= 4'h0;
      level_out <= 1'b0;
      rise_out <= 1'b0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      cnt_r <= cnt_nxt;
      // RL5 RL6 width qualified
      if (stable_w) begin
        level_out <= sync2_r;
      end
      rise_out <= stable_w && sync2_r;
    end
  end

  property p_min_high;
    @(posedge clock) disable iff (!resetn)
      $rose(level_out) |-> $past(sync2_r) && $past(sync2_r, 2);
  endproperty
  a_min_high: assert property (p_min_high) else $error("high level passed too early"); // RL5
  property p_min_low;
    @(posedge clock) disable iff (!resetn)
      $fell(level_out) |-> !$past(sync2_r) && !$past(sync2_r, 2);
  endproperty
  a_min_low: assert property (p_min_low) else $error("low level passed too early"); // RL6
  property p_short_block;
    @(posedge clock) disable iff (!resetn)
      (sync2_r != level_out) && (cnt_r < LIMIT) |=> $stable(level_out);
  endproperty
  a_short_block: assert property (p_short_block) else $error("short glitch passed"); // RL5
endmodule : spsc_pulse_filter

//--- core/spsc_top.sv
// Standby pin state control for port A (eight pins shared with LCD commons),
// two oscillator pins and three peripheral event inputs.
// Assumes mode and hold select come from the standby sequencer on this clock.
//
// Operation
// RL1 - Hold select clear: keep output, block input
// RL2 - Hold select set: float pins, block input
// RL3 - Reset: float pins, input buffer on
// RL4 - Sleep behaves exactly as normal operation
// RL5 - Event high pulse at least two periods
// RL6 - Event low pulse at least two periods
// RL7 - Each port A pin: GPIO or common
// RL8 - Hold select bit only forces float
// RL9 - Reset clears all direction bits
// RL10 - Oscillator pins float in stop, watch
`timescale 1ns/1ps
module spsc_top #(
  parameter int PINS = spsc_pkg::SPSC_PINS,
  parameter int EVENTS = spsc_pkg::SPSC_EVENTS
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [2:0] mode,
  input wire logic pin_hold_select,
  input wire logic dir_we,
  input wire logic [PINS-1:0] dir_wdata,
  input wire logic data_we,
  input wire logic [PINS-1:0] data_wdata,
  input wire logic [PINS-1:0] lcd_sel,
  input wire logic [PINS-1:0] lcd_common_out,
  input wire logic [PINS-1:0] porta_in,
  input wire logic [1:0] osc_en,
  input wire logic [1:0] osc_drive,
  input wire logic [EVENTS-1:0] event_pin,
  output logic [PINS-1:0] porta_out,
  output logic [PINS-1:0] porta_oe,
  output logic [PINS-1:0] porta_ie,
  output logic [PINS-1:0] porta_rdata,
  output logic [PINS-1:0] dir_rdata,
  output logic [1:0] osc_oe,
  output logic [1:0] osc_out,
  output logic [1:0] osc_active,
  output logic [EVENTS-1:0] event_level,
  output logic [EVENTS-1:0] event_rise
);
  typedef enum logic [3:0] {
    SPSC_RUN = 4'h1,
    SPSC_HOLD = 4'h2,
    SPSC_FLOAT = 4'h4,
    SPSC_RST = 4'h8
  } spsc_state_t;

  spsc_state_t state_r;
  spsc_state_t state_nxt;
  logic [PINS-1:0] dir_r;
  logic [PINS-1:0] data_r;
  logic [PINS-1:0] in_sync1_r;
  logic [PINS-1:0] in_sync2_r;
  logic [PINS-1:0] run_out_w;
  logic [PINS-1:0] run_oe_w;
  logic [PINS-1:0] nxt_out_w;
  logic [PINS-1:0] nxt_oe_w;
  logic [PINS-1:0] nxt_ie_w;
  logic [1:0] nxt_osc_oe_w;
  logic [1:0] nxt_osc_act_w;
  logic standby_w;
  logic [EVENTS-1:0] ev_level_w;
  logic [EVENTS-1:0] ev_rise_w;

  assign standby_w = (mode == spsc_pkg::SPSC_MODE_STOP) ||
                     (mode == spsc_pkg::SPSC_MODE_WATCH);
  // RL8 hold select decides
  assign state_nxt = !standby_w ? SPSC_RUN : (pin_hold_select ? SPSC_FLOAT : SPSC_HOLD);

  // RL7 per-pin function select
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      assign run_out_w[gi] = lcd_sel[gi] ? lcd_common_out[gi] : data_r[gi];
      assign run_oe_w[gi] = lcd_sel[gi] | dir_r[gi];
    end
  endgenerate

  // RL1 RL2 RL4 per-state drive
  assign nxt_out_w = (state_nxt == SPSC_HOLD) ? porta_out :
                     (state_nxt == SPSC_FLOAT) ? '0 : run_out_w;
  assign nxt_oe_w = (state_nxt == SPSC_HOLD) ? porta_oe :
                    (state_nxt == SPSC_FLOAT) ? '0 : run_oe_w;
  assign nxt_ie_w = (state_nxt == SPSC_RUN) ? ~lcd_sel : '0;
  // RL10 oscillator pins float in standby
  assign nxt_osc_oe_w = (state_nxt == SPSC_RUN) ? osc_en : 2'h0;
  assign nxt_osc_act_w = (state_nxt == SPSC_RUN) ? osc_en : 2'h0;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_r <= SPSC_RST;
      // RL9 direction cleared
      dir_r <= spsc_pkg::SPSC_DIR_RESET;
      data_r <= spsc_pkg::SPSC_DATA_RESET;
    end else begin
      state_r <= state_nxt;
      if (dir_we) begin
        dir_r <= dir_wdata;
      end
      if (data_we) begin
        data_r <= data_wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      // RL3 reset float input on
      porta_out <= '0;
      porta_oe <= '0;
      porta_ie <= '1;
      // RL10 oscillator resumes at reset
      osc_oe <= spsc_pkg::SPSC_OSC_RESET;
      osc_active <= spsc_pkg::SPSC_OSC_ACT_RESET;
      osc_out <= spsc_pkg::SPSC_OSC_RESET;
    end else begin
      porta_out <= nxt_out_w;
      porta_oe <= nxt_oe_w;
      porta_ie <= nxt_ie_w;
      osc_oe <= nxt_osc_oe_w;
      osc_active <= nxt_osc_act_w;
      osc_out <= osc_drive;
    end
  end

  // Blocked inputs read low; reset input has no functional effect
  always_ff @(posedge clock) begin
    if (!resetn) begin
      in_sync1_r <= '0;
      in_sync2_r <= '0;
      porta_rdata <= '0;
      dir_rdata <= '0;
    end else begin
      in_sync1_r <= porta_in;
      in_sync2_r <= in_sync1_r;
      porta_rdata <= (in_sync2_r & porta_ie & ~dir_r) | (data_r & dir_r);
      dir_rdata <= dir_r;
    end
  end

  generate
    for (gi = 0; gi < EVENTS; gi++) begin : g_ev
      spsc_pulse_filter #(
        .MIN_PULSE(spsc_pkg::SPSC_MIN_PULSE_MCLK)
      ) u_filt (
        .clock(clock),
        .resetn(resetn),
        .pin_in(event_pin[gi]),
        .level_out(ev_level_w[gi]),
        .rise_out(ev_rise_w[gi])
      );
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!resetn) begin
      event_level <= '0;
      event_rise <= '0;
    end else begin
      // Events blocked while standby blocks inputs
      event_level <= (state_nxt == SPSC_RUN) ? ev_level_w : '0;
      event_rise <= (state_nxt == SPSC_RUN) ? ev_rise_w : '0;
    end
  end

  property p_hold;
    @(posedge clock) disable iff (!resetn)
      (state_r == SPSC_HOLD) && standby_w && !pin_hold_select |=>
        $stable(porta_out) && $stable(porta_oe) && porta_ie == '0;
  endproperty
  a_hold: assert property (p_hold) else $error("hold mode lost output"); // RL1
  property p_float;
    @(posedge clock) disable iff (!resetn)
      standby_w && pin_hold_select |=> porta_oe == '0 && porta_ie == '0;
  endproperty
  a_float: assert property (p_float) else $error("float mode drives pin"); // RL2
  property p_reset;
    @(posedge clock) !resetn |=> porta_oe == '0 && porta_ie == '1 && dir_rdata == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset pin state wrong"); // RL3
  property p_sleep;
    @(posedge clock) disable iff (!resetn)
      mode == spsc_pkg::SPSC_MODE_SLEEP |=> porta_oe == $past(run_oe_w)
        && porta_out == $past(run_out_w);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep differs from normal"); // RL4
  property p_lcd;
    @(posedge clock) disable iff (!resetn)
      !standby_w && lcd_sel[0] |=> porta_oe[0] && porta_out[0] == $past(lcd_common_out[0]);
  endproperty
  a_lcd: assert property (p_lcd) else $error("common output not routed"); // RL7
  property p_sel;
    @(posedge clock) disable iff (!resetn)
      standby_w && !pin_hold_select && state_r == SPSC_RUN |=> porta_oe == $past(porta_oe);
  endproperty
  a_sel: assert property (p_sel) else $error("hold select clear floated pins"); // RL8
  property p_dir;
    @(posedge clock) !resetn ##1 resetn && !dir_we |=> dir_rdata == '0;
  endproperty
  a_dir: assert property (p_dir) else $error("direction not cleared"); // RL9
  property p_osc;
    @(posedge clock) disable iff (!resetn)
      standby_w |=> osc_oe == 2'h0 && osc_active == 2'h0;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator pin driven in standby"); // RL10
  property p_osc_reset;
    @(posedge clock) !resetn |=> osc_active == spsc_pkg::SPSC_OSC_ACT_RESET && osc_oe == '0;
  endproperty
  a_osc_reset: assert property (p_osc_reset) else $error("oscillator lost in reset"); // RL10
  property p_gpio;
    @(posedge clock) disable iff (!resetn)
      !standby_w && !lcd_sel[4] && dir_r[4] |=> porta_oe[4] && porta_out[4] == $past(data_r[4]);
  endproperty
  a_gpio: assert property (p_gpio) else $error("port latch not routed"); // RL7
  c_float: cover property (@(posedge clock) disable iff (!resetn) state_r == SPSC_FLOAT);
  c_hold: cover property (@(posedge clock) disable iff (!resetn) state_r == SPSC_HOLD);
  c_event: cover property (@(posedge clock) disable iff (!resetn) event_rise != '0);
  c_sleep: cover property (@(posedge clock) disable iff (!resetn)
    mode == spsc_pkg::SPSC_MODE_SLEEP);
  c_lcd: cover property (@(posedge clock) disable iff (!resetn) (porta_oe & lcd_sel) != '0);
endmodule : spsc_top

//--- tb/spsc_board.sv
// Board model: port A pad levels and event pulse sources.
// Assumes the block drives a pad only where its output enable is high.
`timescale 1ns/1ps
module spsc_board (
  input wire logic clock,
  input wire logic [7:0] porta_out,
  input wire logic [7:0] porta_oe,
  output logic [7:0] porta_in,
  output logic [2:0] event_pin
);
  logic [7:0] ext_r = 8'h3c;
  // Undriven pads show the board level
  assign porta_in = (porta_oe & porta_out) | (~porta_oe & ext_r);
  initial event_pin = 3'h0;
  task automatic pulse(input int ch, input int len);
    @(posedge clock) event_pin[ch] <= 1'b1;
    repeat (len) @(posedge clock);
    event_pin[ch] <= 1'b0;
  endtask : pulse
endmodule : spsc_board

//--- tb/tb_standby_pin_state_control.sv
// Bench for the standby pin state block with a board model.
// Assumes one 25 MHz clock and synchronous active-low reset.
`timescale 1ns/1ps
module tb_standby_pin_state_control;
  logic clock = 1'b0, resetn = 1'b0, pin_hold_select = 1'b0;
  logic dir_we = 1'b0, data_we = 1'b0;
  logic [2:0] mode = 3'h0;
  logic [7:0] dir_wdata = 8'h00, data_wdata = 8'h00;
  logic [7:0] lcd_sel = 8'h00, lcd_common_out = 8'h00;
  logic [1:0] osc_en = 2'h3, osc_drive = 2'h1;
  logic [7:0] porta_in, porta_out, porta_oe, porta_ie, porta_rdata, dir_rdata;
  logic [2:0] event_pin, event_rise, event_level;
  logic [1:0] osc_oe, osc_active, osc_out;
  int bad_count = 0, total_checks = 0;
  always #20 clock = ~clock;
  spsc_top dut (.clock(clock), .resetn(resetn), .mode(mode),
    .pin_hold_select(pin_hold_select), .dir_we(dir_we), .dir_wdata(dir_wdata),
    .data_we(data_we), .data_wdata(data_wdata), .lcd_sel(lcd_sel),
    .lcd_common_out(lcd_common_out), .porta_in(porta_in), .osc_en(osc_en),
    .osc_drive(osc_drive), .event_pin(event_pin), .porta_out(porta_out),
    .porta_oe(porta_oe), .porta_ie(porta_ie), .porta_rdata(porta_rdata),
    .dir_rdata(dir_rdata), .osc_oe(osc_oe), .osc_out(osc_out), .osc_active(osc_active),
    .event_level(event_level), .event_rise(event_rise));
  spsc_board board (.clock(clock), .porta_out(porta_out), .porta_oe(porta_oe),
    .porta_in(porta_in), .event_pin(event_pin));
  task automatic conclude();
    if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle
  task automatic md(input logic [2:0] m, input logic h);
    @(posedge clock);
    mode <= m;
    pin_hold_select <= h;
    settle(2);
  endtask : md
  task automatic t_reset();
    chk(porta_oe, 8'h00);
    chk(porta_ie, 8'hff);
    chk(dir_rdata, 8'h00);
    chk({6'h0, osc_active}, 8'h03);
  endtask : t_reset
  task automatic t_gpio();
    @(posedge clock);
    dir_we <= 1'b1;
    data_we <= 1'b1;
    dir_wdata <= 8'hf0;
    data_wdata <= 8'ha5;
    @(posedge clock);
    dir_we <= 1'b0;
    data_we <= 1'b0;
    settle(4);
    chk(porta_oe, 8'hf0);
    chk(porta_out & 8'hf0, 8'ha0);
    chk(porta_rdata, 8'hac);
    chk({4'h0, osc_oe, osc_out}, 8'h0d);
    md(spsc_pkg::SPSC_MODE_SLEEP, 1'b1);
    settle(3);
    chk(porta_oe, 8'hf0);
    chk(porta_rdata, 8'hac);
  endtask : t_gpio
  task automatic t_standby();
    logic [2:0] m;
    for (int i = 0; i < 4; i++) begin
      m = (i < 2) ? spsc_pkg::SPSC_MODE_STOP : spsc_pkg::SPSC_MODE_WATCH;
      md(spsc_pkg::SPSC_MODE_NORMAL, 1'b0);
      md(m, i[0]);
      settle(3);
      chk(porta_oe, i[0] ? 8'h00 : 8'hf0);
      chk(porta_out & porta_oe, i[0] ? 8'h00 : 8'ha0);
      chk(porta_in, i[0] ? 8'h3c : 8'hac);
      chk(porta_ie, 8'h00);
      chk(porta_rdata, 8'ha0);
      chk({4'h0, osc_oe, osc_active}, 8'h00);
    end
    md(spsc_pkg::SPSC_MODE_NORMAL, 1'b0);
    chk(porta_oe, 8'hf0);
  endtask : t_standby
  task automatic t_lcd();
    @(posedge clock);
    lcd_sel <= 8'h81;
    lcd_common_out <= 8'h80;
    settle(2);
    chk(porta_oe, 8'hf1);
    chk(porta_out & 8'h81, 8'h80);
    chk(porta_ie & 8'h81, 8'h00);
    @(posedge clock);
    lcd_sel <= 8'h00;
  endtask : t_lcd
  task automatic t_midreset();
    @(posedge clock);
    resetn <= 1'b0;
    settle(2);
    chk(porta_oe, 8'h00);
    chk(porta_ie, 8'hff);
    chk(dir_rdata, 8'h00);
    chk({4'h0, osc_oe, osc_active}, 8'h03);
    @(posedge clock);
    resetn <= 1'b1;
    settle(3);
    chk(porta_oe, 8'h00);
  endtask : t_midreset
  task automatic t_event(input int ch, input int len, input logic exp);
    logic seen;
    seen = 1'b0;
    board.pulse(ch, len);
    repeat (10) begin
      settle(1);
      seen |= event_rise[ch];
    end
    chk({6'h0, seen, event_level[ch]}, {6'h0, exp, 1'b0});
  endtask : t_event
  initial begin
    repeat (20) @(posedge clock);
    #1;
    t_reset();
    @(posedge clock);
    resetn <= 1'b1;
    t_gpio();
    t_standby();
    t_lcd();
    t_midreset();
    for (int c = 0; c < 3; c++) begin
      t_event(c, 2, 1'b1);
      t_event(c, 1, 1'b0);
    end
    conclude();
  end
  initial begin
    repeat (3000) @(posedge clock);
    bad_count++;
    conclude();
  end
endmodule : tb_standby_pin_state_control
